// ---- design/psm_pkg.sv ----
package psm_pkg;

    localparam int PSM_ADDR_W = 4;
    localparam int PSM_NUM_REGS = 12;
    localparam int PSM_FLD_W = 2;

    // Register indices on the register port
    localparam logic [3:0] PSM_OFF_PA_LO = 4'h0;
    localparam logic [3:0] PSM_OFF_PA_HI = 4'h1;
    localparam logic [3:0] PSM_OFF_PB_LO = 4'h2;
    localparam logic [3:0] PSM_OFF_PB_HI = 4'h3;
    localparam logic [3:0] PSM_OFF_PC_LO = 4'h4;
    localparam logic [3:0] PSM_OFF_PC_HI = 4'h5;
    localparam logic [3:0] PSM_OFF_PD_LO = 4'h6;
    localparam logic [3:0] PSM_OFF_PD_HI = 4'h7;
    localparam logic [3:0] PSM_OFF_IS0 = 4'h8;
    localparam logic [3:0] PSM_OFF_IS1 = 4'h9;
    localparam logic [3:0] PSM_OFF_IS2 = 4'hA;
    localparam logic [3:0] PSM_OFF_IS3 = 4'hB;

    localparam logic [7:0] PSM_REG_RST = 8'h00;
    localparam logic [7:0] PSM_PC_HI_MASK = 8'h0F;

    // Field slots within a selector (slot n covers bits 2n+1:2n)
    localparam int PSM_SLOT0 = 0;
    localparam int PSM_SLOT1 = 1;
    localparam int PSM_SLOT2 = 2;
    localparam int PSM_SLOT3 = 3;

    // Field codes
    localparam logic [1:0] PSM_CODE0 = 2'h0;
    localparam logic [1:0] PSM_CODE1 = 2'h1;
    localparam logic [1:0] PSM_CODE2 = 2'h2;
    localparam logic [1:0] PSM_CODE3 = 2'h3;

    typedef enum logic [2:0] {
        PSM_K_GPIO,
        PSM_K_ANALOG,
        PSM_K_OUT,
        PSM_K_OD,
        PSM_K_BIDIR
    } psm_kind_t;

    function automatic logic [1:0] psm_fld(input logic [7:0] r, input int slot);
        psm_fld = r[slot*PSM_FLD_W +: PSM_FLD_W];
    endfunction

endpackage

// ---- design/psm_pin_shared_function_mux.sv ----
`timescale 1ns/10ps

// What this block does
// - PA3: 00/11 gpio with hall one, 01 comparator one plus, 10 analog five.
// - PA2: 00/11 gpio with capture and interrupt, 01 timer one, 10 reference.
// - PA1: 00 gpio, 01 analog three, 10 reference input, 11 op-amp plus.
// - PA0: 00/11 gpio with capture and filter, 01 timer zero, 10 analog zero.
// - PA7: 00 gpio with inputs, 01 analog seven, 10 SDA, 11 UART single wire.
// - PA6: 00 gpio, 01 analog eight, 10 timer two, 11 hall B output.
// - PA5/PA4: 00/11 gpio with hall, 01 comparator plus, 10 analog channel.
// - PB3: 00 gpio, 01 comparator three minus, 10 timer zero, 11 op-amp minus.
// - PB2: 00 gpio, 01 comparator two minus, 10 analog nine, 11 timer three.
// - PB1: 00 gpio, 01 comparator one minus, 10 common minus, 11 analog six.
// - PB1 code 10 shorts the three comparator minus inputs to common pin.
// - PB6: 00 gpio, 01 timer three, 10 timer three inverted, 11 op-amp out.
// - PB5: 00 gpio with hall three, 01 SCL, 10 hall A output, 11 UART TX.
// - PB4: 00 gpio, 01 timer two, 10 UART RX/TX, 11 timer two inverted.
// - PC0..PC3: 00 gpio, 01 gate drive A top/bottom, B top/bottom.
// - PC4/PC5: 00 gpio, 01 gate drive C top or bottom.
// - Upper four bits of second port C selector read as zero.
// - Direction 1 makes a gpio pin input, 0 a push-pull output.
module psm_pin_shared_function_mux
    import psm_pkg::*;
#(
    parameter int ADDR_W = PSM_ADDR_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] gpio_a,
    input wire logic [7:0] gpio_b,
    input wire logic [5:0] gpio_c,
    input wire logic [7:0] port_direction_bits_a,
    input wire logic [7:0] port_direction_bits_b,
    input wire logic [5:0] port_direction_bits_c,
    input wire logic tmr0_out,
    input wire logic timer_one_output,
    input wire logic tmr2_out,
    input wire logic tmr2_inv_out,
    input wire logic tmr3_out,
    input wire logic timer_three_inverted_out,
    input wire logic hall_a_output,
    input wire logic hall_b_output,
    input wire logic sda_drive_low,
    input wire logic scl_drive_low,
    input wire logic uart_tx,
    input wire logic uart_rxtx_out,
    input wire logic uart_rxtx_oe,
    input wire logic gate_phase_a_top,
    input wire logic gate_phase_a_bottom,
    input wire logic gate_phase_b_top,
    input wire logic gate_phase_b_bottom,
    input wire logic gate_phase_c_top,
    input wire logic gate_phase_c_bottom,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe,
    output logic [5:0] pc_out,
    output logic [5:0] pc_oe,
    output logic [7:0] pa_analog,
    output logic [7:0] pb_analog,
    output logic [7:0] pa_din_en,
    output logic [7:0] pb_din_en,
    output logic cmp_neg_short
);

    logic [7:0] regs_r [PSM_NUM_REGS];
    logic [7:0] regs_nxt [PSM_NUM_REGS];
    psm_kind_t kind_a [8];
    psm_kind_t kind_b [8];
    logic [7:0] sig_a;
    logic [7:0] sig_b;
    logic [5:0] gate_c;
    logic [5:0] gsel_c;
    logic [7:0] pa_lo;
    logic [7:0] pa_hi;
    logic [7:0] pb_lo;
    logic [7:0] pb_hi;
    logic [7:0] pc_lo;
    logic [7:0] pc_hi;

    function automatic logic [1:0] pin_drive(input psm_kind_t k, input logic s,
                                             input logic g, input logic d,
                                             input logic boe);
        case (k)
            PSM_K_GPIO: pin_drive = {~d, g};
            PSM_K_OUT: pin_drive = {1'b1, s};
            PSM_K_OD: pin_drive = {s, 1'b0};
            PSM_K_BIDIR: pin_drive = {boe, s};
            default: pin_drive = 2'h0;
        endcase
    endfunction

    // Register file writes
    always_comb begin
        for (int i = 0; i < PSM_NUM_REGS; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        if (reg_wr && (reg_addr < ADDR_W'(PSM_NUM_REGS))) begin
            regs_nxt[reg_addr] = reg_wdata;
            if (reg_addr == ADDR_W'(PSM_OFF_PC_HI)) begin
                regs_nxt[reg_addr] = reg_wdata & PSM_PC_HI_MASK;
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < PSM_NUM_REGS; i++) begin
            if (!resetn) begin
                regs_r[i] <= PSM_REG_RST;
            end else begin
                regs_r[i] <= regs_nxt[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && (reg_addr < ADDR_W'(PSM_NUM_REGS))) begin
            reg_rdata <= regs_r[reg_addr];
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    assign pa_lo = regs_nxt[PSM_OFF_PA_LO];
    assign pa_hi = regs_nxt[PSM_OFF_PA_HI];
    assign pb_lo = regs_nxt[PSM_OFF_PB_LO];
    assign pb_hi = regs_nxt[PSM_OFF_PB_HI];
    assign pc_lo = regs_nxt[PSM_OFF_PC_LO];
    assign pc_hi = regs_nxt[PSM_OFF_PC_HI];

    // Port A decode
    always_comb begin
        kind_a = '{default: PSM_K_GPIO};
        sig_a = 8'h00;
        case (psm_fld(pa_lo, PSM_SLOT0))
            PSM_CODE1: begin
                kind_a[0] = PSM_K_OUT;
                sig_a[0] = tmr0_out;
            end
            PSM_CODE2: kind_a[0] = PSM_K_ANALOG;
            default: ;
        endcase
        if (psm_fld(pa_lo, PSM_SLOT1) != PSM_CODE0) begin
            kind_a[1] = PSM_K_ANALOG;
        end
        case (psm_fld(pa_lo, PSM_SLOT2))
            PSM_CODE1: begin
                kind_a[2] = PSM_K_OUT;
                sig_a[2] = timer_one_output;
            end
            PSM_CODE2: kind_a[2] = PSM_K_ANALOG;
            default: ;
        endcase
        case (psm_fld(pa_lo, PSM_SLOT3))
            PSM_CODE1, PSM_CODE2: kind_a[3] = PSM_K_ANALOG;
            default: ;
        endcase
        case (psm_fld(pa_hi, PSM_SLOT0))
            PSM_CODE1, PSM_CODE2: kind_a[4] = PSM_K_ANALOG;
            default: ;
        endcase
        case (psm_fld(pa_hi, PSM_SLOT1))
            PSM_CODE1, PSM_CODE2: kind_a[5] = PSM_K_ANALOG;
            default: ;
        endcase
        case (psm_fld(pa_hi, PSM_SLOT2))
            PSM_CODE1: kind_a[6] = PSM_K_ANALOG;
            PSM_CODE2: begin
                kind_a[6] = PSM_K_OUT;
                sig_a[6] = tmr2_out;
            end
            PSM_CODE3: begin
                kind_a[6] = PSM_K_OUT;
                sig_a[6] = hall_b_output;
            end
            default: ;
        endcase
        case (psm_fld(pa_hi, PSM_SLOT3))
            PSM_CODE1: kind_a[7] = PSM_K_ANALOG;
            PSM_CODE2: begin
                kind_a[7] = PSM_K_OD;
                sig_a[7] = sda_drive_low;
            end
            PSM_CODE3: begin
                kind_a[7] = PSM_K_BIDIR;
                sig_a[7] = uart_rxtx_out;
            end
            default: ;
        endcase
    end

    // Port B decode; slots for PB0 and PB7 stay gpio
    always_comb begin
        kind_b = '{default: PSM_K_GPIO};
        sig_b = 8'h00;
        case (psm_fld(pb_lo, PSM_SLOT1))
            PSM_CODE1, PSM_CODE2, PSM_CODE3: kind_b[1] = PSM_K_ANALOG;
            default: ;
        endcase
        case (psm_fld(pb_lo, PSM_SLOT2))
            PSM_CODE1, PSM_CODE2: kind_b[2] = PSM_K_ANALOG;
            PSM_CODE3: begin
                kind_b[2] = PSM_K_OUT;
                sig_b[2] = tmr3_out;
            end
            default: ;
        endcase
        case (psm_fld(pb_lo, PSM_SLOT3))
            PSM_CODE1, PSM_CODE3: kind_b[3] = PSM_K_ANALOG;
            PSM_CODE2: begin
                kind_b[3] = PSM_K_OUT;
                sig_b[3] = tmr0_out;
            end
            default: ;
        endcase
        case (psm_fld(pb_hi, PSM_SLOT0))
            PSM_CODE1: begin
                kind_b[4] = PSM_K_OUT;
                sig_b[4] = tmr2_out;
            end
            PSM_CODE2: begin
                kind_b[4] = PSM_K_BIDIR;
                sig_b[4] = uart_rxtx_out;
            end
            PSM_CODE3: begin
                kind_b[4] = PSM_K_OUT;
                sig_b[4] = tmr2_inv_out;
            end
            default: ;
        endcase
        case (psm_fld(pb_hi, PSM_SLOT1))
            PSM_CODE1: begin
                kind_b[5] = PSM_K_OD;
                sig_b[5] = scl_drive_low;
            end
            PSM_CODE2: begin
                kind_b[5] = PSM_K_OUT;
                sig_b[5] = hall_a_output;
            end
            PSM_CODE3: begin
                kind_b[5] = PSM_K_OUT;
                sig_b[5] = uart_tx;
            end
            default: ;
        endcase
        case (psm_fld(pb_hi, PSM_SLOT2))
            PSM_CODE1: begin
                kind_b[6] = PSM_K_OUT;
                sig_b[6] = tmr3_out;
            end
            PSM_CODE2: begin
                kind_b[6] = PSM_K_OUT;
                sig_b[6] = timer_three_inverted_out;
            end
            PSM_CODE3: kind_b[6] = PSM_K_ANALOG;
            default: ;
        endcase
    end

    // Port C gate-drive select; reserved codes fall back to gpio
    assign gate_c = {gate_phase_c_bottom, gate_phase_c_top, gate_phase_b_bottom,
                     gate_phase_b_top, gate_phase_a_bottom, gate_phase_a_top};
    assign gsel_c = {psm_fld(pc_hi, PSM_SLOT1) == PSM_CODE1,
                     psm_fld(pc_hi, PSM_SLOT0) == PSM_CODE1,
                     psm_fld(pc_lo, PSM_SLOT3) == PSM_CODE1,
                     psm_fld(pc_lo, PSM_SLOT2) == PSM_CODE1,
                     psm_fld(pc_lo, PSM_SLOT1) == PSM_CODE1,
                     psm_fld(pc_lo, PSM_SLOT0) == PSM_CODE1};

    generate
        for (genvar i = 0; i < 8; i++) begin : g_ab
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    {pa_oe[i], pa_out[i]} <= 2'h0;
                    {pb_oe[i], pb_out[i]} <= 2'h0;
                    pa_analog[i] <= 1'b0;
                    pb_analog[i] <= 1'b0;
                    pa_din_en[i] <= 1'b0;
                    pb_din_en[i] <= 1'b0;
                end else begin
                    {pa_oe[i], pa_out[i]} <= pin_drive(kind_a[i], sig_a[i], gpio_a[i],
                        port_direction_bits_a[i], uart_rxtx_oe);
                    {pb_oe[i], pb_out[i]} <= pin_drive(kind_b[i], sig_b[i], gpio_b[i],
                        port_direction_bits_b[i], uart_rxtx_oe);
                    pa_analog[i] <= (kind_a[i] == PSM_K_ANALOG);
                    pb_analog[i] <= (kind_b[i] == PSM_K_ANALOG);
                    pa_din_en[i] <= ((kind_a[i] == PSM_K_GPIO) && port_direction_bits_a[i])
                        || (kind_a[i] == PSM_K_OD) || (kind_a[i] == PSM_K_BIDIR);
                    pb_din_en[i] <= ((kind_b[i] == PSM_K_GPIO) && port_direction_bits_b[i])
                        || (kind_b[i] == PSM_K_OD) || (kind_b[i] == PSM_K_BIDIR);
                end
            end
        end
        for (genvar j = 0; j < 6; j++) begin : g_c
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    pc_out[j] <= 1'b0;
                    pc_oe[j] <= 1'b0;
                end else if (gsel_c[j]) begin
                    pc_out[j] <= gate_c[j];
                    pc_oe[j] <= 1'b1;
                end else begin
                    pc_out[j] <= gpio_c[j];
                    pc_oe[j] <= ~port_direction_bits_c[j];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmp_neg_short <= 1'b0;
        end else begin
            cmp_neg_short <= (psm_fld(pb_lo, PSM_SLOT1) == PSM_CODE2);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_pa3_analog: assert property (
        pa_analog[3] == (regs_r[PSM_OFF_PA_LO][7:6] inside {2'h1, 2'h2}))
        else $error("PA3 analog select mismatch");
    a_pa2_timer: assert property (
        $rose(resetn) or regs_r[PSM_OFF_PA_LO][5:4] != 2'h1
        or (pa_oe[2] && pa_out[2] == $past(timer_one_output)))
        else $error("PA2 timer one output not driven");
    a_pa1_opamp: assert property (
        regs_r[PSM_OFF_PA_LO][3:2] == 2'h3 |-> pa_analog[1] && !pa_oe[1])
        else $error("PA1 op-amp input still driven");
    a_pa7_sda: assert property (
        regs_r[PSM_OFF_PA_HI][7:6] == 2'h2 |-> !pa_out[7] && !pa_analog[7])
        else $error("PA7 SDA not open drain");
    a_pb1_short: assert property (
        cmp_neg_short == (regs_r[PSM_OFF_PB_LO][3:2] == 2'h2)
        && (!cmp_neg_short || pb_analog[1]))
        else $error("Comparator short mismatch");
    a_pb5_scl: assert property (
        regs_r[PSM_OFF_PB_HI][3:2] == 2'h1 |-> pb_din_en[5] && !pb_out[5])
        else $error("PB5 SCL path wrong");
    a_pc_gate: assert property (
        regs_r[PSM_OFF_PC_LO][1:0] == 2'h1 && $past(resetn) |->
        pc_oe[0] && pc_out[0] == $past(gate_phase_a_top))
        else $error("PC0 gate drive not routed");
    a_pc_hi_zero: assert property (
        reg_wr && reg_addr == ADDR_W'(PSM_OFF_PC_HI) ##1 reg_rd && reg_addr ==
        ADDR_W'(PSM_OFF_PC_HI) |=> reg_rdata == ($past(reg_wdata, 2) & PSM_PC_HI_MASK))
        else $error("Unimplemented bits read nonzero");
    a_gpio_dir: assert property (
        regs_r[PSM_OFF_PB_LO][7:6] == 2'h0 && $past(resetn) |->
        pb_oe[3] == !$past(port_direction_bits_b[3]))
        else $error("PB3 direction not honoured");
    a_wr_update: assert property (
        reg_wr && reg_addr == ADDR_W'(PSM_OFF_PA_HI) |=>
        regs_r[PSM_OFF_PA_HI] == $past(reg_wdata)
        && pa_analog[4] == ($past(reg_wdata[1:0]) inside {2'h1, 2'h2}))
        else $error("Selector write did not route at next edge");

    c_short: cover property (reg_wr ##1 cmp_neg_short);
    c_uart: cover property (regs_r[PSM_OFF_PA_HI][7:6] == 2'h3 && pa_oe[7]);
    c_gate_all: cover property (pc_oe == 6'h3F);

endmodule

// ---- tb/psm_periph_model.sv ----
`timescale 1ns/10ps

// Peripheral and gate-driver side: levels follow pat one cycle later while enabled
module psm_periph_model
    import psm_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic en,
    input wire logic [18:0] pat,
    output logic tmr0_out,
    output logic timer_one_output,
    output logic tmr2_out,
    output logic tmr2_inv_out,
    output logic tmr3_out,
    output logic timer_three_inverted_out,
    output logic hall_a_output,
    output logic hall_b_output,
    output logic sda_drive_low,
    output logic scl_drive_low,
    output logic uart_tx,
    output logic uart_rxtx_out,
    output logic uart_rxtx_oe,
    output logic gate_phase_a_top,
    output logic gate_phase_a_bottom,
    output logic gate_phase_b_top,
    output logic gate_phase_b_bottom,
    output logic gate_phase_c_top,
    output logic gate_phase_c_bottom
);
    logic [18:0] lvl_r;

    // Disabled peripherals hold their outputs idle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lvl_r <= 19'h00000;
        end else begin
            lvl_r <= en ? pat : 19'h00000;
        end
    end

    assign {gate_phase_c_bottom, gate_phase_c_top, gate_phase_b_bottom, gate_phase_b_top,
        gate_phase_a_bottom, gate_phase_a_top, uart_rxtx_oe, uart_rxtx_out, uart_tx,
        scl_drive_low, sda_drive_low, hall_b_output, hall_a_output, timer_three_inverted_out,
        tmr3_out, tmr2_inv_out, tmr2_out, timer_one_output, tmr0_out} = lvl_r;
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps

module tb_top
    import psm_pkg::*;
;
    localparam logic [7:0] KG = {PSM_K_GPIO, 5'h00};
    localparam logic [7:0] KA = {PSM_K_ANALOG, 5'h00};
    localparam logic [7:0] KB = {PSM_K_BIDIR, 5'h00};
    logic clk, resetn, reg_wr, reg_rd, en, cmp_neg_short;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, gpio_a, gpio_b, dir_a, dir_b;
    logic [5:0] gpio_c, dir_c, pc_out, pc_oe;
    logic [7:0] pa_out, pa_oe, pb_out, pb_oe, pa_analog, pb_analog, pa_din_en, pb_din_en;
    logic [18:0] pat;
    logic tmr0_out, timer_one_output, tmr2_out, tmr2_inv_out, tmr3_out;
    logic timer_three_inverted_out, hall_a_output, hall_b_output, sda_drive_low;
    logic scl_drive_low, uart_tx, uart_rxtx_out, uart_rxtx_oe, gate_phase_a_top;
    logic gate_phase_a_bottom, gate_phase_b_top, gate_phase_b_bottom;
    logic gate_phase_c_top, gate_phase_c_bottom;
    int miscompares;
    int n_tests;

    psm_periph_model model (.clk(clk), .resetn(resetn), .en(en), .pat(pat),
        .tmr0_out(tmr0_out), .timer_one_output(timer_one_output), .tmr2_out(tmr2_out),
        .tmr2_inv_out(tmr2_inv_out), .tmr3_out(tmr3_out),
        .timer_three_inverted_out(timer_three_inverted_out), .hall_a_output(hall_a_output),
        .hall_b_output(hall_b_output), .sda_drive_low(sda_drive_low),
        .scl_drive_low(scl_drive_low), .uart_tx(uart_tx), .uart_rxtx_out(uart_rxtx_out),
        .uart_rxtx_oe(uart_rxtx_oe), .gate_phase_a_top(gate_phase_a_top),
        .gate_phase_a_bottom(gate_phase_a_bottom), .gate_phase_b_top(gate_phase_b_top),
        .gate_phase_b_bottom(gate_phase_b_bottom), .gate_phase_c_top(gate_phase_c_top),
        .gate_phase_c_bottom(gate_phase_c_bottom));

    psm_pin_shared_function_mux dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .gpio_a(gpio_a), .gpio_b(gpio_b), .gpio_c(gpio_c), .port_direction_bits_a(dir_a),
        .port_direction_bits_b(dir_b), .port_direction_bits_c(dir_c),
        .tmr0_out(tmr0_out), .timer_one_output(timer_one_output), .tmr2_out(tmr2_out),
        .tmr2_inv_out(tmr2_inv_out), .tmr3_out(tmr3_out),
        .timer_three_inverted_out(timer_three_inverted_out), .hall_a_output(hall_a_output),
        .hall_b_output(hall_b_output), .sda_drive_low(sda_drive_low),
        .scl_drive_low(scl_drive_low), .uart_tx(uart_tx), .uart_rxtx_out(uart_rxtx_out),
        .uart_rxtx_oe(uart_rxtx_oe), .gate_phase_a_top(gate_phase_a_top),
        .gate_phase_a_bottom(gate_phase_a_bottom), .gate_phase_b_top(gate_phase_b_top),
        .gate_phase_b_bottom(gate_phase_b_bottom), .gate_phase_c_top(gate_phase_c_top),
        .gate_phase_c_bottom(gate_phase_c_bottom), .pa_out(pa_out), .pa_oe(pa_oe),
        .pb_out(pb_out), .pb_oe(pb_oe), .pc_out(pc_out), .pc_oe(pc_oe),
        .pa_analog(pa_analog), .pb_analog(pb_analog), .pa_din_en(pa_din_en),
        .pb_din_en(pb_din_en), .cmp_neg_short(cmp_neg_short));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        cmp(reg_rdata, exp);
    endtask

    // Write then read with no gap between the strobes
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        cmp(reg_rdata, exp);
    endtask

    function automatic logic [3:0] exp_pin(input int pt, input int n, input logic [1:0] c,
        input logic [18:0] p, input logic g, input logic d);
        logic [7:0] r;
        r = KG;
        if (pt == 0) begin
            case (n)
                0: r = c == 2'h1 ? {PSM_K_OUT, 5'h00} : c == 2'h2 ? KA : KG;
                1: r = c == 2'h0 ? KG : KA;
                2: r = c == 2'h1 ? {PSM_K_OUT, 5'h01} : c == 2'h2 ? KA : KG;
                3, 4, 5: r = c == 2'h1 || c == 2'h2 ? KA : KG;
                6: r = c == 2'h1 ? KA : c == 2'h2 ? {PSM_K_OUT, 5'h02}
                    : c == 2'h3 ? {PSM_K_OUT, 5'h07} : KG;
                default: r = c == 2'h1 ? KA : c == 2'h2 ? {PSM_K_OD, 5'h08}
                    : c == 2'h3 ? KB : KG;
            endcase
        end else if (pt == 1) begin
            case (n)
                1: r = c == 2'h0 ? KG : KA;
                2: r = c == 2'h3 ? {PSM_K_OUT, 5'h04} : c == 2'h0 ? KG : KA;
                3: r = c == 2'h2 ? {PSM_K_OUT, 5'h00} : c == 2'h0 ? KG : KA;
                4: r = c == 2'h1 ? {PSM_K_OUT, 5'h02} : c == 2'h2 ? KB
                    : c == 2'h3 ? {PSM_K_OUT, 5'h03} : KG;
                5: r = c == 2'h1 ? {PSM_K_OD, 5'h09} : c == 2'h2 ? {PSM_K_OUT, 5'h06}
                    : c == 2'h3 ? {PSM_K_OUT, 5'h0A} : KG;
                6: r = c == 2'h1 ? {PSM_K_OUT, 5'h04} : c == 2'h2 ? {PSM_K_OUT, 5'h05}
                    : c == 2'h3 ? KA : KG;
                default: r = KG;
            endcase
        end else if (c == 2'h1) begin
            r = {PSM_K_OUT, 5'h0D + 5'(n)};
        end
        case (psm_kind_t'(r[7:5]))
            PSM_K_GPIO: exp_pin = {1'h0, ~d, g, d};
            PSM_K_ANALOG: exp_pin = 4'h8;
            PSM_K_OUT: exp_pin = {2'h1, p[r[4:0]], 1'h0};
            PSM_K_OD: exp_pin = {1'h0, p[r[4:0]], 2'h1};
            default: exp_pin = {1'h0, p[12], p[11], 1'h1};
        endcase
    endfunction

    task automatic chk_port(input int pt, input logic [1:0] c);
        logic [3:0] e;
        logic [7:0] ea, eo, ey, ed, m, g, d;
        logic [18:0] p;
        #1;
        p = en ? pat : 19'h00000;
        g = pt == 0 ? gpio_a : pt == 1 ? gpio_b : {2'h0, gpio_c};
        d = pt == 0 ? dir_a : pt == 1 ? dir_b : {2'h0, dir_c};
        {ea, eo, ey, ed} = 32'h00000000;
        for (int n = 0; n < (pt == 2 ? 6 : 8); n++) begin
            e = exp_pin(pt, n, c, p, g[n], d[n]);
            {ea[n], eo[n], ey[n], ed[n]} = e;
        end
        m = ~ea;
        if (pt == 0) begin
            cmp(pa_analog, ea);
            cmp(pa_oe, eo);
            cmp(pa_out, ey);
            cmp(pa_din_en & m, ed & m);
        end else if (pt == 1) begin
            cmp(pb_analog, ea);
            cmp(pb_oe, eo);
            cmp(pb_out, ey);
            cmp(pb_din_en & m, ed & m);
            cmp({7'h00, cmp_neg_short}, {7'h00, c == 2'h2});
        end else begin
            cmp({2'h0, pc_oe}, eo);
            cmp({2'h0, pc_out}, ey);
        end
    endtask

    task automatic flip_and_settle();
        @(posedge clk);
        gpio_a <= ~gpio_a;
        gpio_b <= ~gpio_b;
        gpio_c <= ~gpio_c;
        dir_a <= ~dir_a;
        dir_b <= ~dir_b;
        dir_c <= ~dir_c;
        pat <= ~pat;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_regs();
        logic [7:0] v, d;
        for (int i = 0; i < 13; i++) rd(4'(i), PSM_REG_RST);
        for (int k = 0; k < 2; k++) begin
            v = k == 0 ? 8'hB4 : 8'h4B;
            for (int i = 0; i < 13; i++) begin
                d = i == 2 ? v & 8'hFC : i == 3 ? v & 8'h3F : v;
                wr_rd(4'(i), d, i > 11 ? 8'h00 : i == 5 ? d & PSM_PC_HI_MASK : d);
            end
        end
    endtask

    task automatic t_reset_mid();
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 12; i++) rd(4'(i), PSM_REG_RST);
        chk_port(0, 2'h0);
        chk_port(1, 2'h0);
    endtask

    task automatic t_port_a();
        for (int c = 0; c < 4; c++) begin
            en <= 1'b0;
            wr(PSM_OFF_PA_LO, {4{2'(c)}});
            wr(PSM_OFF_PA_HI, {4{2'(c)}});
            chk_port(0, 2'(c));
            en <= 1'b1;
            repeat (3) @(posedge clk);
            chk_port(0, 2'(c));
            flip_and_settle();
            chk_port(0, 2'(c));
        end
    endtask

    task automatic t_port_b();
        for (int c = 0; c < 4; c++) begin
            en <= 1'b0;
            wr(PSM_OFF_PB_LO, {{3{2'(c)}}, 2'h0});
            wr(PSM_OFF_PB_HI, {2'h0, {3{2'(c)}}});
            chk_port(1, 2'(c));
            en <= 1'b1;
            repeat (3) @(posedge clk);
            chk_port(1, 2'(c));
            flip_and_settle();
            chk_port(1, 2'(c));
        end
    endtask

    task automatic t_port_c();
        for (int c = 3; c >= 0; c--) begin
            en <= 1'b0;
            wr(PSM_OFF_PC_LO, {4{2'(c)}});
            wr(PSM_OFF_PC_HI, {4{2'(c)}});
            en <= 1'b1;
            repeat (3) @(posedge clk);
            chk_port(2, 2'(c));
            flip_and_settle();
            chk_port(2, 2'(c));
        end
        // Leave every gate-drive field on its drive code
        wr(PSM_OFF_PC_LO, 8'h55);
        wr(PSM_OFF_PC_HI, 8'h55);
        rd(PSM_OFF_PC_LO, 8'h55);
        rd(PSM_OFF_PC_HI, 8'h05);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        miscompares = 0;
        n_tests = 0;
        resetn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        en = 1'b0;
        pat = 19'h5A5A5;
        gpio_a = 8'hA5;
        gpio_b = 8'h3C;
        gpio_c = 6'h2A;
        dir_a = 8'h0F;
        dir_b = 8'hF0;
        dir_c = 6'h15;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_reset_mid();
        t_port_a();
        t_port_b();
        t_port_c();
        end_of_test();
    end
endmodule
